// ===== rtl/fpl_cyc_if.sv
// Purpose: per-cycle stroke timing and sense data to the helper blocks
// Assumes: all signals on sys_clk
// Notes: driven by the protection top only
`timescale 1ns/100ps
interface fpl_cyc_if;
    import fpl_pkg::*;
    logic cycle_tick;
    logic primary;
    logic secondary;
    logic ovp_raw;
    logic clear;
    logic [CODE_W-1:0] aux_code;
    modport src (output cycle_tick, primary, secondary, ovp_raw, clear, aux_code);
    modport snk (input cycle_tick, primary, secondary, ovp_raw, clear, aux_code);
endinterface

// ===== rtl/fpl_opp_limit.sv
// Purpose: peak current limit lowered by mains voltage sensed on aux pin
// Assumes: aux_code is valid while primary stroke is high
// Notes: sample taken on the last cycle of the primary stroke
`timescale 1ns/100ps
module fpl_opp_limit
    import fpl_pkg::*;
(
    input wire logic sys_clk, // system clock
    input wire logic reset, // sync reset, high
    fpl_cyc_if.snk cyc, // stroke timing and aux code
    output logic [CODE_W-1:0] peak_limit // peak current limit code
);

    logic primary_d;
    logic [CODE_W-1:0] sample;
    wire primary_end = primary_d && !cyc.primary;
    wire [CODE_W-1:0] excess = (sample > OPP_START_CODE) ? sample - OPP_START_CODE : 8'h00;
    wire [2*CODE_W-1:0] reduce = excess * OPP_SLOPE;
    wire [CODE_W-1:0] span = LIMIT_MAX - LIMIT_MIN;
    wire [CODE_W-1:0] next_limit = (reduce >= {8'h00, span}) ? LIMIT_MIN : LIMIT_MAX - reduce[CODE_W-1:0];

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            primary_d <= 1'b0;
            sample <= 8'h00;
            peak_limit <= LIMIT_MAX;
        end else begin
            primary_d <= cyc.primary;
            if (cyc.primary) begin
                sample <= cyc.aux_code;
            end
            peak_limit <= next_limit;
        end
    end

    AST_OPP_BOUND: assert property (@(posedge sys_clk) disable iff (reset)
        primary_end ##1 1'b1 |=> peak_limit <= LIMIT_MAX && peak_limit >= LIMIT_MIN
        && (($past(sample, 1) > OPP_START_CODE + span) -> peak_limit == LIMIT_MIN))
        else $error("peak limit out of range after primary stroke");

endmodule

// ===== rtl/fpl_ovp_filter.sv
// Purpose: integrator and up-down event counter for output overvoltage
// Assumes: cycle_tick marks the end of one switching cycle
// Notes: counter saturates at the trip value
`timescale 1ns/100ps
module fpl_ovp_filter
    import fpl_pkg::*;
(
    input wire logic sys_clk, // system clock
    input wire logic reset, // sync reset, high
    fpl_cyc_if.snk cyc, // stroke timing
    output logic [OVP_CNT_W-1:0] ovp_count, // event counter
    output logic ovp_event, // last cycle saw overvoltage
    output logic ovp_trip // counter reached trip
);

    logic [INTEG_W-1:0] integ;
    logic [INTEG_W-1:0] next_integ;
    logic [OVP_CNT_W-1:0] next_count;
    wire event_now = integ >= INTEG_TRIP;
    wire integ_full = integ == {INTEG_W{1'b1}};
    wire integ_zero = integ == INTEG_RESET;

    // ------------------------------------------------------------
    // integrator: only the secondary stroke counts
    // ------------------------------------------------------------
    assign next_integ = (cyc.clear || cyc.cycle_tick) ? INTEG_RESET :
                        !cyc.secondary ? integ :
                        (cyc.ovp_raw && !integ_full) ? integ + 6'h01 :
                        (!cyc.ovp_raw && !integ_zero) ? integ - 6'h01 : integ;

    assign next_count = cyc.clear ? OVP_CNT_RESET :
                        !cyc.cycle_tick ? ovp_count :
                        event_now ? ((ovp_count >= OVP_CNT_TRIP) ? OVP_CNT_TRIP : ovp_count + OVP_CNT_UP) :
                        (ovp_count >= OVP_CNT_DOWN) ? ovp_count - OVP_CNT_DOWN : OVP_CNT_RESET;

    assign ovp_trip = ovp_count >= OVP_CNT_TRIP;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            integ <= INTEG_RESET;
            ovp_count <= OVP_CNT_RESET;
            ovp_event <= 1'b0;
        end else begin
            integ <= next_integ;
            ovp_count <= next_count;
            if (cyc.cycle_tick) begin
                ovp_event <= event_now;
            end
        end
    end

    AST_OVP_EVENT: assert property (@(posedge sys_clk) disable iff (reset)
        cyc.cycle_tick && !cyc.clear |=> ovp_event == $past(event_now))
        else $error("overvoltage event flag mismatch");
    AST_OVP_UP: assert property (@(posedge sys_clk) disable iff (reset)
        cyc.cycle_tick && !cyc.clear && event_now && ovp_count < OVP_CNT_TRIP
        |=> ovp_count == $past(ovp_count) + OVP_CNT_UP)
        else $error("counter did not step up by one");
    AST_OVP_DOWN: assert property (@(posedge sys_clk) disable iff (reset)
        cyc.cycle_tick && !cyc.clear && !event_now
        |=> ovp_count == (($past(ovp_count) >= OVP_CNT_DOWN) ? $past(ovp_count) - OVP_CNT_DOWN : OVP_CNT_RESET))
        else $error("counter did not step down by two");

endmodule

// ===== rtl/fpl_pkg.sv
// Purpose: shared constants for the flyback protection logic
// Assumes: 100 MHz sys_clk, one switching cycle marked by an end pulse
// Notes: analogue thresholds arrive as comparator outputs
package fpl_pkg;

    // ------------------------------------------------------------
    // clock and pfc hysteresis timing
    // ------------------------------------------------------------
    localparam int CLK_KHZ = 100000;
    localparam int PFC_ON_KHZ = 86;
    localparam int PFC_OFF_KHZ = 48;
    // longest period that still enables: round down
    localparam int PFC_ON_CYC = CLK_KHZ / PFC_ON_KHZ;
    // shortest period that disables: round up
    localparam int PFC_OFF_CYC = (CLK_KHZ + PFC_OFF_KHZ - 1) / PFC_OFF_KHZ;
    localparam int PERIOD_W = 12;

    // ------------------------------------------------------------
    // synchronised comparator inputs (bit positions)
    // ------------------------------------------------------------
    localparam int PIN_N = 7;
    localparam int PIN_CTRL_GND = 0;
    localparam int PIN_CTRL_2V5 = 1;
    localparam int PIN_CTRL_4V5 = 2;
    localparam int PIN_AUX_OVP = 3;
    localparam int PIN_VCC_UVLO = 4;
    localparam int PIN_VCC_START = 5;
    localparam int PIN_MAINS_RST = 6;

    // ------------------------------------------------------------
    // overvoltage filter
    // ------------------------------------------------------------
    localparam int OVP_CNT_W = 4;
    localparam logic [OVP_CNT_W-1:0] OVP_CNT_RESET = 4'h0;
    localparam logic [OVP_CNT_W-1:0] OVP_CNT_UP = 4'h1;
    localparam logic [OVP_CNT_W-1:0] OVP_CNT_DOWN = 4'h2;
    localparam logic [OVP_CNT_W-1:0] OVP_CNT_TRIP = 4'h8;
    localparam int INTEG_W = 6;
    localparam logic [INTEG_W-1:0] INTEG_RESET = 6'h00;
    localparam logic [INTEG_W-1:0] INTEG_TRIP = 6'h08;

    // ------------------------------------------------------------
    // overpower limit (aux current code to peak limit code)
    // ------------------------------------------------------------
    localparam int CODE_W = 8;
    localparam logic [CODE_W-1:0] OPP_START_CODE = 8'h20;
    localparam logic [CODE_W-1:0] OPP_SLOPE = 8'h01;
    localparam logic [CODE_W-1:0] LIMIT_MAX = 8'hc0;
    localparam logic [CODE_W-1:0] LIMIT_MIN = 8'h40;

    typedef enum logic [3:0] {
        ST_WAIT    = 4'b0001,
        ST_RUN     = 4'b0010,
        ST_RESTART = 4'b0100,
        ST_LATCH   = 4'b1000
    } fpl_state_t;

endpackage

// ===== rtl/fpl_protect.sv
// Purpose: flyback protection top: control pin, overvoltage latch, overpower limit
// Assumes: comparator outputs are asynchronous; stroke strobes are on sys_clk
// Notes: latch only clears on the mains reset detector
`timescale 1ns/100ps

module fpl_protect
    import fpl_pkg::*;
(
    input wire logic sys_clk, // system clock
    input wire logic reset, // sync reset, high
    input wire logic [PIN_N-1:0] pin_cmp, // async comparator outputs
    input wire logic cycle_tick, // end of switching cycle pulse
    input wire logic primary_stroke, // primary stroke level
    input wire logic secondary_stroke, // secondary stroke level
    input wire logic max_on_time_hit, // on-time limit reached pulse
    input wire logic [CODE_W-1:0] aux_current_code, // aux pin current code
    input wire logic latch_variant, // high: control fault latches
    output logic flyback_enable, // flyback may switch
    output logic pfc_enable, // pfc may switch
    output logic ctrl_pullup_enable, // resistive pull-up on control pin
    output logic ctrl_csrc_enable, // current source on control pin
    output logic ctrl_pulldown, // pull-down switch on control pin
    output logic protect_latched, // protection latch
    output logic safe_restart, // in safe restart
    output logic [CODE_W-1:0] peak_limit, // peak current limit code
    output logic [OVP_CNT_W-1:0] ovp_count // overvoltage event counter
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [PIN_N-1:0] pin_meta;
    logic [PIN_N-1:0] pin_sync;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= pin_cmp;
            pin_sync <= pin_meta;
        end
    end

    wire ctrl_gnd = pin_sync[PIN_CTRL_GND];
    wire ctrl_2v5 = pin_sync[PIN_CTRL_2V5];
    wire ctrl_fault = pin_sync[PIN_CTRL_4V5];
    wire vcc_uvlo = pin_sync[PIN_VCC_UVLO];
    wire vcc_start = pin_sync[PIN_VCC_START];
    wire mains_reset = pin_sync[PIN_MAINS_RST];

    // ------------------------------------------------------------
    // helper blocks
    // ------------------------------------------------------------
    fpl_state_t state;
    fpl_state_t next_state;
    logic ovp_event;
    logic ovp_trip;
    fpl_cyc_if cyc ();

    assign cyc.cycle_tick = cycle_tick;
    assign cyc.primary = primary_stroke;
    assign cyc.secondary = secondary_stroke;
    assign cyc.ovp_raw = pin_sync[PIN_AUX_OVP];
    assign cyc.aux_code = aux_current_code;
    assign cyc.clear = state != ST_RUN;

    fpl_ovp_filter u_ovp (
        .sys_clk(sys_clk),
        .reset(reset),
        .cyc(cyc),
        .ovp_count(ovp_count),
        .ovp_event(ovp_event),
        .ovp_trip(ovp_trip)
    );

    fpl_opp_limit u_opp (
        .sys_clk(sys_clk),
        .reset(reset),
        .cyc(cyc),
        .peak_limit(peak_limit)
    );

    // ------------------------------------------------------------
    // protection state machine
    // ------------------------------------------------------------
    logic uvlo_seen;
    wire is_run = state == ST_RUN;
    wire ctrl_to_latch = ctrl_fault && latch_variant;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_WAIT: begin
                if (vcc_start) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (ovp_trip || ctrl_to_latch) begin
                    next_state = ST_LATCH;
                end else if (ctrl_fault || max_on_time_hit) begin
                    next_state = ST_RESTART;
                end else if (vcc_uvlo) begin
                    next_state = ST_WAIT;
                end
            end
            ST_RESTART: begin
                if (uvlo_seen && vcc_start) begin
                    next_state = ST_RUN;
                end
            end
            ST_LATCH: begin
                if (mains_reset) begin
                    next_state = ST_WAIT;
                end
            end
            default: next_state = ST_WAIT;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state <= ST_WAIT;
            uvlo_seen <= 1'b0;
        end else begin
            state <= next_state;
            // one full undervoltage-to-start cycle before retry
            uvlo_seen <= (state == ST_RESTART) && (uvlo_seen || vcc_uvlo);
        end
    end

    assign protect_latched = state == ST_LATCH;
    assign safe_restart = state == ST_RESTART;

    // ------------------------------------------------------------
    // control pin handling
    // ------------------------------------------------------------
    // grounded pin only parks the flyback; it is not a fault
    assign flyback_enable = is_run && !ctrl_gnd && !ctrl_fault && !ovp_trip;
    assign ctrl_pullup_enable = !ctrl_2v5;
    assign ctrl_csrc_enable = ctrl_2v5;
    assign ctrl_pulldown = !flyback_enable;

    // ------------------------------------------------------------
    // pfc enable with frequency hysteresis
    // ------------------------------------------------------------
    logic [PERIOD_W-1:0] period_cnt;
    logic [PERIOD_W-1:0] next_period;
    logic pfc_on;
    wire period_max = period_cnt == {PERIOD_W{1'b1}};
    // at the tick the counter holds one less than the period length
    wire freq_high = period_cnt < PERIOD_W'(PFC_ON_CYC);
    wire freq_low = period_cnt >= PERIOD_W'(PFC_OFF_CYC - 1);

    // counter saturates: very slow cycles simply read as low frequency
    assign next_period = cycle_tick ? '0 : (period_max ? period_cnt : period_cnt + 12'h001);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            period_cnt <= '0;
            pfc_on <= 1'b0;
        end else begin
            period_cnt <= next_period;
            if (!is_run) begin
                pfc_on <= 1'b0;
            end else if (cycle_tick && freq_high) begin
                pfc_on <= 1'b1;
            end else if (cycle_tick && freq_low) begin
                pfc_on <= 1'b0;
            end
        end
    end

    assign pfc_enable = pfc_on && is_run && !ctrl_fault && !ovp_trip;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_GND_INHIBIT: assert property (@(posedge sys_clk) disable iff (reset)
        ctrl_gnd |-> !flyback_enable && (is_run -> !protect_latched))
        else $error("flyback enabled with grounded control pin");
    AST_PULLUP_SWAP: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(pin_meta[PIN_CTRL_2V5]) |=> !ctrl_pullup_enable && ctrl_csrc_enable)
        else $error("pull-up not swapped for current source");
    AST_CTRL_FAULT: assert property (@(posedge sys_clk) disable iff (reset)
        is_run && ctrl_fault |-> !flyback_enable && !pfc_enable
        ##1 (latch_variant ? protect_latched : safe_restart) || $past(ovp_trip))
        else $error("control pin fault not handled");
    AST_PULLDOWN: assert property (@(posedge sys_clk) disable iff (reset)
        !is_run |-> ctrl_pulldown && !flyback_enable)
        else $error("control pin not pulled down while disabled");
    AST_LATCH_ON_8: assert property (@(posedge sys_clk) disable iff (reset)
        is_run && ovp_count == OVP_CNT_TRIP |-> !flyback_enable && !pfc_enable ##1 protect_latched)
        else $error("counter at eight did not latch");
    AST_LATCH_HOLD: assert property (@(posedge sys_clk) disable iff (reset)
        protect_latched && !mains_reset |=> protect_latched)
        else $error("latch left without mains reset");
    AST_PFC_ON: assert property (@(posedge sys_clk) disable iff (reset)
        is_run && cycle_tick && period_cnt < PERIOD_W'(PFC_ON_CYC) ##1 is_run |-> pfc_on)
        else $error("pfc not enabled at high frequency");
    AST_PFC_OFF: assert property (@(posedge sys_clk) disable iff (reset)
        cycle_tick && period_cnt >= PERIOD_W'(PFC_OFF_CYC - 1) |=> !pfc_enable)
        else $error("pfc not disabled at low frequency");
    AST_ON_TIME: assert property (@(posedge sys_clk) disable iff (reset)
        is_run && max_on_time_hit && !ovp_trip && !ctrl_to_latch |=> safe_restart)
        else $error("on-time limit did not restart");
    AST_RESTART_CLR: assert property (@(posedge sys_clk) disable iff (reset)
        safe_restart ##1 safe_restart |-> ovp_count == OVP_CNT_RESET && !flyback_enable)
        else $error("restart did not clear counter");

endmodule

// ===== sim/fpl_stage_model.sv
// Purpose: power stage model: switching cycles, strokes, aux winding sense
// Assumes: bench sets period and overvoltage; changes at falling edge
// Notes: aux code outside primary shows the inverse, never a stale value
`timescale 1ns/100ps
module fpl_stage_model
    import fpl_pkg::*;
(
    input wire logic sys_clk, // system clock
    input wire logic [PERIOD_W-1:0] period, // cycle length, 64 minimum
    input wire logic ovp_on, // output above overvoltage level
    input wire logic [CODE_W-1:0] aux_level, // mains sense code
    output logic cycle_tick, // end of switching cycle
    output logic primary_stroke, // primary stroke level
    output logic secondary_stroke, // secondary stroke level
    output logic aux_ovp, // aux overvoltage comparator
    output logic [CODE_W-1:0] aux_current_code // aux current code
);
    logic [PERIOD_W-1:0] pos = '0;

    always @(negedge sys_clk) begin
        pos <= (pos >= period - 12'h001) ? '0 : pos + 12'h001;
    end

    assign cycle_tick = (pos == period - 12'h001);
    assign primary_stroke = (pos < 12'h010);
    assign secondary_stroke = (pos >= 12'h010) && (pos < 12'h030);
    // comparator only sees the winding while the secondary conducts
    assign aux_ovp = ovp_on && secondary_stroke;
    assign aux_current_code = primary_stroke ? aux_level : ~aux_level;
endmodule

// ===== sim/tb.sv
// Purpose: self-checking bench for the flyback protection top
// Assumes: pins change at falling edge; partner makes the cycles
// Notes: checks land a few cycles after inputs to clear the synchronisers
`timescale 1ns/100ps
module tb;
    import fpl_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [PIN_N-1:0] pins = '0;
    logic max_on_time_hit = 1'b0;
    logic latch_variant = 1'b0;
    logic [PERIOD_W-1:0] period = 12'h040;
    logic ovp_on = 1'b0;
    logic [CODE_W-1:0] aux_level = 8'h00;
    logic cycle_tick, primary_stroke, secondary_stroke, aux_ovp;
    logic [CODE_W-1:0] aux_current_code, peak_limit;
    logic flyback_enable, pfc_enable, ctrl_pullup_enable, ctrl_csrc_enable;
    logic ctrl_pulldown, protect_latched, safe_restart;
    logic [OVP_CNT_W-1:0] ovp_count;
    int error_cnt = 0;
    int comparisons = 0;

    always #5 sys_clk = ~sys_clk;

    fpl_stage_model stage (.sys_clk(sys_clk), .period(period), .ovp_on(ovp_on), .aux_level(aux_level),
        .cycle_tick(cycle_tick), .primary_stroke(primary_stroke), .secondary_stroke(secondary_stroke),
        .aux_ovp(aux_ovp), .aux_current_code(aux_current_code));

    fpl_protect dut (.sys_clk(sys_clk), .reset(reset),
        .pin_cmp({pins[6:4], aux_ovp, pins[2:0]}), .cycle_tick(cycle_tick),
        .primary_stroke(primary_stroke), .secondary_stroke(secondary_stroke),
        .max_on_time_hit(max_on_time_hit), .aux_current_code(aux_current_code),
        .latch_variant(latch_variant), .flyback_enable(flyback_enable), .pfc_enable(pfc_enable),
        .ctrl_pullup_enable(ctrl_pullup_enable), .ctrl_csrc_enable(ctrl_csrc_enable),
        .ctrl_pulldown(ctrl_pulldown), .protect_latched(protect_latched), .safe_restart(safe_restart),
        .peak_limit(peak_limit), .ovp_count(ovp_count));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] expd, input string what);
        comparisons++;
        if (seen !== expd) begin
            error_cnt++;
            $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, expd);
        end
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // bounded wait for n cycle ends, then let the counters settle
    task automatic wait_ticks(input int n);
        int t;
        for (int i = 0; i < n; i++) begin
            t = 0;
            while (cycle_tick !== 1'b1 && t < 5000) begin
                @(posedge sys_clk);
                t++;
            end
            if (t >= 5000)
                check(8'h00, 8'h01, "tick timeout");
            @(posedge sys_clk);
        end
        cycles(2);
    endtask

    // supply drops to undervoltage, then climbs past start-up
    task automatic supply_cycle;
        pins[5] = 1'b0;
        pins[4] = 1'b1;
        cycles(5);
        pins[4] = 1'b0;
        pins[5] = 1'b1;
        cycles(5);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_pins;
        check(flyback_enable, 0, "fb off at reset");
        check(ctrl_pulldown, 1, "pulldown at reset");
        check(ctrl_pullup_enable, 1, "pullup at reset");
        check(peak_limit, LIMIT_MAX, "limit at reset");
        pins[5] = 1'b1;
        cycles(5);
        check(flyback_enable, 1, "fb on in run");
        check(ctrl_pulldown, 0, "pulldown off");
        pins[0] = 1'b1;
        cycles(4);
        check(flyback_enable, 0, "ground short inhibits");
        check(ctrl_pulldown, 1, "pulldown when off");
        check({safe_restart, protect_latched}, 0, "short is no fault");
        pins[0] = 1'b0;
        pins[1] = 1'b1;
        cycles(4);
        check({ctrl_pullup_enable, ctrl_csrc_enable}, 2'b01, "current source bias");
        check(flyback_enable, 1, "fb back on");
        pins[1] = 1'b0;
        cycles(4);
        check({ctrl_pullup_enable, ctrl_csrc_enable}, 2'b10, "pullup bias");
        $display("test reset_pins done");
    endtask

    task automatic t_ovp;
        wait_ticks(1);
        ovp_on = 1'b1;
        for (int i = 1; i <= 3; i++) begin
            wait_ticks(1);
            check(ovp_count, i, "count up");
        end
        ovp_on = 1'b0;
        wait_ticks(1);
        check(ovp_count, 1, "count down two");
        wait_ticks(1);
        check(ovp_count, 0, "floor at zero");
        ovp_on = 1'b1;
        wait_ticks(7);
        check({protect_latched, ovp_count}, 8'h07, "seven not enough");
        wait_ticks(1);
        check({protect_latched, flyback_enable, pfc_enable}, 3'b100, "latched off");
        ovp_on = 1'b0;
        supply_cycle();
        check({protect_latched, flyback_enable}, 2'b10, "no restart");
        pins[6] = 1'b1;
        cycles(5);
        pins[6] = 1'b0;
        cycles(5);
        check({protect_latched, flyback_enable}, 2'b01, "mains reset clears");
        $display("test ovp done");
    endtask

    task automatic t_pfc;
        period = 12'd1000;
        wait_ticks(3);
        check(pfc_enable, 1, "pfc on fast");
        period = 12'd1600;
        wait_ticks(3);
        check(pfc_enable, 1, "hysteresis holds on");
        period = 12'd2200;
        wait_ticks(3);
        check(pfc_enable, 0, "pfc off slow");
        period = 12'd1600;
        wait_ticks(2);
        check(pfc_enable, 0, "hysteresis holds off");
        period = 12'd1163;
        wait_ticks(3);
        check(pfc_enable, 0, "just below on frequency");
        period = 12'd1162;
        wait_ticks(3);
        check(pfc_enable, 1, "on at on frequency");
        period = 12'd2083;
        wait_ticks(3);
        check(pfc_enable, 1, "just above off frequency");
        period = 12'd2084;
        wait_ticks(3);
        check(pfc_enable, 0, "off at off frequency");
        period = 12'h040;
        wait_ticks(3);
        $display("test pfc done");
    endtask

    task automatic t_opp;
        logic [7:0] codes[4] = '{8'h30, 8'h10, 8'hff, 8'h9f};
        logic [7:0] lims[4] = '{8'hb0, 8'hc0, 8'h40, 8'h41};
        for (int i = 0; i < 4; i++) begin
            aux_level = codes[i];
            wait_ticks(1);
            check(peak_limit, lims[i], "peak limit");
        end
        $display("test opp done");
    endtask

    task automatic t_faults;
        check(pfc_enable, 1, "pfc running");
        pins[2] = 1'b1;
        cycles(4);
        check({safe_restart, protect_latched, flyback_enable, pfc_enable}, 4'b1000, "ctrl open");
        check(ctrl_pulldown, 1, "pulldown in restart");
        pins[2] = 1'b0;
        supply_cycle();
        check({safe_restart, flyback_enable}, 2'b01, "restart retried");
        ovp_on = 1'b1;
        wait_ticks(2);
        ovp_on = 1'b0;
        check(ovp_count, 2, "count before restart");
        max_on_time_hit = 1'b1;
        cycles(1);
        max_on_time_hit = 1'b0;
        cycles(3);
        check({safe_restart, flyback_enable, ovp_count}, 6'h20, "on-time restart");
        supply_cycle();
        latch_variant = 1'b1;
        pins[2] = 1'b1;
        cycles(4);
        pins[2] = 1'b0;
        supply_cycle();
        check({protect_latched, safe_restart, flyback_enable}, 3'b100, "ctrl latches");
        pins[6] = 1'b1;
        cycles(5);
        pins[6] = 1'b0;
        cycles(5);
        check(protect_latched, 0, "latch cleared");
        $display("test faults done");
    endtask

    initial begin
        cycles(2);
        reset = 1'b0;
        cycles(3);
        t_reset_pins();
        t_ovp();
        t_pfc();
        t_opp();
        t_faults();
        conclude();
    end

    initial begin
        #900000;
        error_cnt++;
        conclude();
    end
endmodule
